//--- rtl/critical_fault_log.sv
// Critical fault log trigger selection and content configuration
`timescale 1ns/10ps
//
// Summary of operation
// - Two-bit control picks stored content: both, flags, results, or nothing.
// - Low undervoltage enable register arms inputs 1 to 8 undervoltage logging.
// - Mid register low nibble arms undervoltage logging on inputs 9 to 12.
// - Mid register high nibble arms overvoltage logging on inputs 1 to 4.
// - High register bits 0 to 3 arm overvoltage logging on inputs 5 to 8.
// - High register bit 4 arms overvoltage logging on input 9, large variant.
// - An enabled fault shuts down sequenced outputs; only when the logger is ready and content is not off does it start the nonvolatile store.
// - A stored log locks the logger; writing one to unlock bit re-arms it.
// - High register bits 5 to 7 arm overvoltage logging on inputs 10 to 12.
// - Two warning enable registers arm early-warning logging on all inputs.
module critical_fault_log #(
  parameter int NUM_INPUTS = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic [NUM_INPUTS-1:0] underCond,
  input wire logic [NUM_INPUTS-1:0] overCond,
  input wire logic [NUM_INPUTS-1:0] warnCond,
  input wire logic logDone,
  output logic shutdownPulse,
  output logic logStart,
  output logic storeFlags,
  output logic storeResults,
  output logic logLocked
);

  // Only the two documented variants are served; any other count stops elaboration
  if (NUM_INPUTS != fault_log_pkg::INPUTS_LARGE && NUM_INPUTS != fault_log_pkg::INPUTS_SMALL) begin
    $error("NUM_INPUTS must be 8 or 12");
  end

  localparam int N = NUM_INPUTS;
  localparam logic [11:0] INPUT_MASK = (N == fault_log_pkg::INPUTS_LARGE) ? 12'hFFF : 12'h0FF;

  logic [1:0] contentSel_q;
  logic [7:0] uvEnLow_q;
  logic [7:0] uoEnMid_q;
  logic [7:0] ovEnHigh_q;
  logic [7:0] warnEnLow_q;
  logic [3:0] warnEnHigh_q;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic triggerPrev_q;
  logic shutdown_q;
  logic logStart_q;
  logic storeFlags_q;
  logic storeResults_q;
  fault_log_pkg::log_state_type state_q;
  logic [11:0] underEn;
  logic [11:0] overEn;
  logic [11:0] warnEn;
  logic [11:0] underFull;
  logic [11:0] overFull;
  logic [11:0] warnFull;
  logic underHit;
  logic overHit;
  logic warnHit;
  logic triggerAny;
  logic faultEvent;
  logic unlockWrite;
  fault_log_pkg::log_mode_type logMode;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Write decode; bits of absent inputs are never stored, so they read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      contentSel_q <= fault_log_pkg::RESET_CONTENT;
      uvEnLow_q <= fault_log_pkg::RESET_ENABLE;
      uoEnMid_q <= fault_log_pkg::RESET_ENABLE;
      ovEnHigh_q <= fault_log_pkg::RESET_ENABLE;
      warnEnLow_q <= fault_log_pkg::RESET_ENABLE;
      warnEnHigh_q <= fault_log_pkg::RESET_ENABLE[3:0];
    end else if (regWrite) begin
      case (regAddr)
        fault_log_pkg::ADDR_CONTENT_SEL: contentSel_q <= regWrData[1:0];
        fault_log_pkg::ADDR_UV_EN_LOW: uvEnLow_q <= regWrData;
        fault_log_pkg::ADDR_UO_EN_MID: uoEnMid_q <= regWrData & {4'hF, INPUT_MASK[11:8]};
        fault_log_pkg::ADDR_OV_EN_HIGH: ovEnHigh_q <= regWrData & {INPUT_MASK[11:8], 4'hF};
        fault_log_pkg::ADDR_WARN_EN_LOW: warnEnLow_q <= regWrData;
        fault_log_pkg::ADDR_WARN_EN_HIGH: warnEnHigh_q <= regWrData[3:0] & INPUT_MASK[11:8];
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses and unused bits answer zero
  always_comb begin
    rdData_d = 8'h00;
    case (regAddr)
      fault_log_pkg::ADDR_CONTENT_SEL: rdData_d = {6'h00, contentSel_q};
      fault_log_pkg::ADDR_UV_EN_LOW: rdData_d = uvEnLow_q;
      fault_log_pkg::ADDR_UO_EN_MID: rdData_d = uoEnMid_q;
      fault_log_pkg::ADDR_OV_EN_HIGH: rdData_d = ovEnHigh_q;
      fault_log_pkg::ADDR_WARN_EN_LOW: rdData_d = warnEnLow_q;
      fault_log_pkg::ADDR_WARN_EN_HIGH: rdData_d = {4'h0, warnEnHigh_q};
      fault_log_pkg::ADDR_LOG_UNLOCK: rdData_d[fault_log_pkg::LOCK_STATUS_BIT] = (state_q == fault_log_pkg::ST_LOCKED);
      default: rdData_d = 8'h00;
    endcase
  end

  // Read data is registered, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (regRead) begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection

  // Enable vectors, input 1 in bit 0
  assign underEn = {uoEnMid_q[3:0], uvEnLow_q} & INPUT_MASK;
  assign overEn = {ovEnHigh_q, uoEnMid_q[7:4]} & INPUT_MASK;
  assign warnEn = {warnEnHigh_q, warnEnLow_q} & INPUT_MASK;

  // Widen the condition inputs of the small variant with zeros
  assign underFull = 12'(underCond);
  assign overFull = 12'(overCond);
  assign warnFull = 12'(warnCond);

  trigger_reduce #(.WIDTH(12)) underReduce (.cond(underFull), .enable(underEn), .hit(underHit));
  trigger_reduce #(.WIDTH(12)) overReduce (.cond(overFull), .enable(overEn), .hit(overHit));
  trigger_reduce #(.WIDTH(12)) warnReduce (.cond(warnFull), .enable(warnEn), .hit(warnHit));

  // A held fault launches once; it must clear before it can fire again
  assign triggerAny = underHit | overHit | warnHit;
  assign faultEvent = triggerAny & ~triggerPrev_q;
  assign logMode = fault_log_pkg::log_mode_type'(contentSel_q);
  assign unlockWrite = regWrite && regAddr == fault_log_pkg::ADDR_LOG_UNLOCK && regWrData[fault_log_pkg::UNLOCK_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      triggerPrev_q <= 1'b0;
    end else begin
      triggerPrev_q <= triggerAny;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown and log launch

  // Shutdown fires on every enabled fault, even while the log is locked
  always_ff @(posedge clk) begin
    if (rst) begin
      shutdown_q <= 1'b0;
    end else begin
      shutdown_q <= faultEvent;
    end
  end

  // Launch pulse with content selection, held until the next launch
  always_ff @(posedge clk) begin
    if (rst) begin
      logStart_q <= 1'b0;
      storeFlags_q <= 1'b0;
      storeResults_q <= 1'b0;
    end else begin
      logStart_q <= 1'b0;
      if (faultEvent && state_q == fault_log_pkg::ST_READY && logMode != fault_log_pkg::LOG_OFF) begin
        logStart_q <= 1'b1;
        storeFlags_q <= ~contentSel_q[fault_log_pkg::FLAGS_OFF_BIT];
        storeResults_q <= ~contentSel_q[fault_log_pkg::RESULTS_OFF_BIT];
      end
    end
  end

  // Lock sequencing; a done arriving with an unlock still locks, so no log is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= fault_log_pkg::ST_READY;
    end else begin
      case (state_q)
        fault_log_pkg::ST_READY: begin
          if (faultEvent && logMode != fault_log_pkg::LOG_OFF) begin
            state_q <= fault_log_pkg::ST_STORING;
          end
        end
        fault_log_pkg::ST_STORING: begin
          if (logDone) begin
            state_q <= fault_log_pkg::ST_LOCKED;
          end
        end
        fault_log_pkg::ST_LOCKED: begin
          if (unlockWrite) begin
            state_q <= fault_log_pkg::ST_READY;
          end
        end
        default: state_q <= fault_log_pkg::ST_READY;
      endcase
    end
  end

  assign shutdownPulse = shutdown_q;
  assign logStart = logStart_q;
  assign storeFlags = storeFlags_q;
  assign storeResults = storeResults_q;
  assign logLocked = (state_q == fault_log_pkg::ST_LOCKED);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_content_select: assert property (logStart_q |-> storeFlags_q == ~$past(contentSel_q[1])
    && storeResults_q == ~$past(contentSel_q[0]))
    else $error("stored content does not follow control field");
  // Only from ready: a storing logger, or a locked one with no unlock write, stays out of ready
  a_logger_off: assert property (faultEvent && logMode == fault_log_pkg::LOG_OFF
    && state_q == fault_log_pkg::ST_READY |=> !logStart_q && state_q == fault_log_pkg::ST_READY)
    else $error("log launched while logger off");
  a_under_low: assert property (|(underFull[7:0] & uvEnLow_q) |-> triggerAny)
    else $error("enabled undervoltage on inputs 1-8 missed");
  a_under_high: assert property (|(underFull[11:8] & uoEnMid_q[3:0]) |-> triggerAny)
    else $error("enabled undervoltage on inputs 9-12 missed");
  a_over_first: assert property (|(overFull[3:0] & uoEnMid_q[7:4]) |-> triggerAny)
    else $error("enabled overvoltage on inputs 1-4 missed");
  a_over_mid: assert property (|(overFull[7:4] & ovEnHigh_q[3:0]) |-> triggerAny)
    else $error("enabled overvoltage on inputs 5-8 missed");
  a_over_nine: assert property (overFull[8] && ovEnHigh_q[4] |-> triggerAny)
    else $error("enabled overvoltage on input 9 missed");
  a_over_top: assert property (|(overFull[11:9] & ovEnHigh_q[7:5]) |-> triggerAny)
    else $error("enabled overvoltage on inputs 10-12 missed");
  a_warn_any: assert property (|(warnFull & {warnEnHigh_q, warnEnLow_q}) |-> triggerAny)
    else $error("enabled early warning missed");
  a_shutdown_launch: assert property (faultEvent && state_q == fault_log_pkg::ST_READY
    && logMode != fault_log_pkg::LOG_OFF |=> shutdown_q && logStart_q ##1 !logStart_q)
    else $error("fault did not shut down and launch log");
  a_lock_holds: assert property (state_q == fault_log_pkg::ST_LOCKED && !unlockWrite |=> logLocked
    && !logStart_q)
    else $error("lock released without unlock");
  a_trigger_gate: assert property (!$stable(shutdown_q) && shutdown_q |-> $past(triggerAny)
    && !$past(triggerPrev_q))
    else $error("shutdown without an enabled fault");

  c_log_stored: cover property (logStart_q ##[1:20] logLocked);
  c_unlock_rearm: cover property (logLocked ##1 !logLocked);
  c_locked_fault: cover property (logLocked && faultEvent);

endmodule

//--- rtl/fault_log_pkg.sv
// Package: register map, field layout, reset values and modes of the critical fault logger
package fault_log_pkg;

  // Register addresses on the configuration port
  localparam logic [7:0] ADDR_CONTENT_SEL = 8'h47;
  localparam logic [7:0] ADDR_UV_EN_LOW = 8'h48;
  localparam logic [7:0] ADDR_UO_EN_MID = 8'h49;
  localparam logic [7:0] ADDR_OV_EN_HIGH = 8'h4A;
  localparam logic [7:0] ADDR_WARN_EN_LOW = 8'h4B;
  localparam logic [7:0] ADDR_WARN_EN_HIGH = 8'h4C;
  localparam logic [7:0] ADDR_LOG_UNLOCK = 8'h5D;

  // Field positions
  localparam int UNLOCK_BIT = 1;
  localparam int LOCK_STATUS_BIT = 0;
  localparam int FLAGS_OFF_BIT = 1;
  localparam int RESULTS_OFF_BIT = 0;

  // Reset values
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [1:0] RESET_CONTENT = 2'h0;

  // Input counts of the two device variants
  localparam int INPUTS_LARGE = 12;
  localparam int INPUTS_SMALL = 8;

  // What a critical fault stores
  typedef enum logic [1:0] {
    LOG_BOTH = 2'b00,
    LOG_FLAGS = 2'b01,
    LOG_RESULTS = 2'b10,
    LOG_OFF = 2'b11
  } log_mode_type;

  // Logger sequencing
  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_STORING = 2'b01,
    ST_LOCKED = 2'b10
  } log_state_type;

endpackage

//--- rtl/trigger_reduce.sv
// Gated OR of confirmed threshold conditions against their enable bits
`timescale 1ns/10ps
module trigger_reduce #(
  parameter int WIDTH = 12
) (
  input wire logic [WIDTH-1:0] cond,
  input wire logic [WIDTH-1:0] enable,
  output logic hit
);

  // Any enabled confirmed condition raises the hit
  assign hit = |(cond & enable);

endmodule

//--- bench/critical_fault_log_tb_top.sv
// Self-checking bench for the critical fault log trigger and content block
`timescale 1ns/10ps
module critical_fault_log_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic [11:0] underCond = 12'h000;
  logic [11:0] overCond = 12'h000;
  logic [11:0] warnCond = 12'h000;
  logic logDone = 1'b0;
  logic shutdownPulse;
  logic logStart;
  logic storeFlags;
  logic storeResults;
  logic logLocked;
  int mismatches = 0;
  int samplesChecked = 0;
  int cycles = 0;
  logic [7:0] regAddrs [8] = '{8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h5D, 8'h50};
  logic [7:0] wrVals [8] = '{8'hFF, 8'hA5, 8'h5A, 8'hC3, 8'h3C, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] rdVals [8] = '{8'h03, 8'hA5, 8'h5A, 8'hC3, 8'h3C, 8'h0F, 8'h00, 8'h00};

  critical_fault_log #(.NUM_INPUTS(12)) dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData), .underCond(underCond),
    .overCond(overCond), .warnCond(warnCond), .logDone(logDone), .shutdownPulse(shutdownPulse),
    .logStart(logStart), .storeFlags(storeFlags), .storeResults(storeResults), .logLocked(logLocked));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the full run needs about two thousand cycles
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("mismatch at %0t: run did not finish in time", $time);
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compare with case inequality so an unknown never matches
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One write strobe, released the edge after it is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Read strobe, data checked once the registered answer has landed
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    #1;
    chk(regRdData, exp, msg);
  endtask

  // Raise one condition, count output pulses over a short window, then drop it
  task automatic fire(input int k, input int i, input logic expShut, input logic expStart);
    int nShut;
    int nStart;
    nShut = 0;
    nStart = 0;
    @(posedge clk);
    case (k)
      0: underCond[i] <= 1'b1;
      1: overCond[i] <= 1'b1;
      default: warnCond[i] <= 1'b1;
    endcase
    repeat (4) begin
      @(posedge clk);
      #1;
      if (shutdownPulse === 1'b1) nShut++;
      if (logStart === 1'b1) nStart++;
    end
    @(posedge clk);
    underCond <= 12'h000;
    overCond <= 12'h000;
    warnCond <= 12'h000;
    repeat (2) @(posedge clk);
    chk(nShut[7:0], {7'h00, expShut}, "shutdown pulse count");
    chk(nStart[7:0], {7'h00, expStart}, "log start count");
  endtask

  // Enable register and bit that arm each condition kind and input
  function automatic logic [7:0] en_addr(input int k, input int i);
    if (k == 0) return (i < 8) ? 8'h48 : 8'h49;
    if (k == 1) return (i < 4) ? 8'h49 : 8'h4A;
    return (i < 8) ? 8'h4B : 8'h4C;
  endfunction

  function automatic int en_bit(input int k, input int i);
    if (k == 1) return (i < 4) ? i + 4 : i - 4;
    return i % 8;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [1:0] mode;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values, masked bits and unmapped addresses
    for (int n = 0; n < 8; n++) rd(regAddrs[n], 8'h00, "reset value");
    for (int n = 0; n < 8; n++) wr(regAddrs[n], wrVals[n]);
    for (int n = 0; n < 8; n++) rd(regAddrs[n], rdVals[n], "readback");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h48, 8'h00, "cleared by second reset");
    // Every trigger source once, cycling the four content codes
    for (int n = 0; n < 36; n++) begin
      mode = n[1:0];
      for (int a = 8'h48; a <= 8'h4C; a++) wr(a[7:0], 8'h00);
      wr(8'h47, {6'h00, mode});
      fire(n / 12, n % 12, 1'b0, 1'b0);
      wr(en_addr(n / 12, n % 12), 8'h01 << en_bit(n / 12, n % 12));
      fire(n / 12, n % 12, 1'b1, mode != 2'b11);
      if (mode != 2'b11) chk({6'h00, storeFlags, storeResults}, {6'h00, ~mode}, "stored content");
      fire(n / 12, n % 12, 1'b1, 1'b0);
      @(posedge clk);
      logDone <= 1'b1;
      @(posedge clk);
      logDone <= 1'b0;
      @(posedge clk);
      #1;
      chk({7'h00, logLocked}, {7'h00, mode != 2'b11}, "locked after store");
      rd(8'h5D, {7'h00, mode != 2'b11}, "lock status");
      fire(n / 12, n % 12, 1'b1, 1'b0);
      wr(8'h5D, 8'h02);
      @(posedge clk);
      #1;
      chk({7'h00, logLocked}, 8'h00, "unlocked");
    end
    complete_run();
  end
endmodule
